// *** pcfgt_bank.v ***
// pmbus configuration and telemetry command register bank
// Operation
// - output-voltage words: unsigned mantissa, exponent -12
// - other quantities: 11-bit mantissa, 5-bit exponent
// - operation bit 7 enables the output
// - on/off config: five bits, two writable
// - command bit zero ignores operation enable
// - power-up waits on pin and operation
// - pin-required bit needs pin asserted
// - input thresholds 32 to 46 volts
// - input words carry exponent -3
// - positive linear mantissas keep sign zero
// - store-all commits settings to non-volatile
// - turn-on delay 10 to 500 ms
// - rise time 15 to 500 ms
// - timing words carry exponent -1
// - setpoint 8.10 to 13.20 volts, mode -12
// - operation bits 5:2 select margining
// - margin levels unsigned, exponent -12
// - vout readback adds signed offset
// - vin offset: exponent -3, signed mantissa
// - vin readback: gain over 8192 plus offset
// - iout readback carries exponent -4
// - writes reach working registers only
`default_nettype none
`include "pcfgt_regs.vh"
module pcfgt_bank (
   // clock and reset
   input  wire        ref_clk,
   input  wire        nrst,
   // command port from the pmbus slave
   input  wire        cmd_wr,
   input  wire [7:0]  cmd_code,
   input  wire [15:0] cmd_wdata,
   output reg  [15:0] cmd_rdata,
   output reg         cmd_ack,
   output reg         cmd_nack,
   // analog on/off pin, asynchronous
   input  wire        onoff_pin,
   // raw converter samples and factory calibration
   input  wire [15:0] vout_adc,
   input  wire [10:0] vin_adc,
   input  wire [10:0] iout_adc,
   input  wire [15:0] vout_cal_ofs,
   input  wire [10:0] vin_cal_ofs,
   input  wire [15:0] vin_cal_gain,
   // non-volatile store port
   output reg         nvm_store,
   output reg  [15:0] nvm_vout,
   output reg  [15:0] nvm_mhigh,
   output reg  [15:0] nvm_mlow,
   output reg  [10:0] nvm_vin_on,
   output reg  [10:0] nvm_vin_off,
   output reg  [10:0] nvm_ton_delay,
   output reg  [10:0] nvm_ton_rise,
   // converter control
   output reg         output_enable,
   output reg  [1:0]  margin_sel,
   output reg  [15:0] vout_target,
   output wire [10:0] vin_on_level,
   output wire [10:0] vin_off_level,
   output wire [10:0] ton_delay_level,
   output wire [10:0] ton_rise_level
);
   // ----------------------------------------------------------------
   // working registers
   // ----------------------------------------------------------------
   reg  [7:0]  operation_reg;
   reg  [7:0]  on_off_source_config_reg;
   reg  [15:0] vout_set_reg;
   reg  [15:0] vout_mhigh_reg;
   reg  [15:0] vout_mlow_reg;
   reg  [10:0] vin_on_reg;
   reg  [10:0] vin_off_reg;
   reg  [10:0] ton_delay_reg;
   reg  [10:0] ton_rise_reg;
   reg  [15:0] read_next;
   reg         accept;
   wire        pin_sync;
   wire [10:0] w_mant;
   wire [4:0]  w_exp;
   wire        w_pos;

   assign w_mant = cmd_wdata[10:0];
   assign w_exp  = cmd_wdata[15:11];
   // sign bit must stay clear for positive-only words
   assign w_pos  = ~cmd_wdata[10];

   assign vin_on_level    = vin_on_reg;
   assign vin_off_level   = vin_off_reg;
   assign ton_delay_level = ton_delay_reg;
   assign ton_rise_level  = ton_rise_reg;

   // ----------------------------------------------------------------
   // on/off pin synchroniser
   // ----------------------------------------------------------------
   pcfgt_sync u_pin_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .d_in    (onoff_pin),
      .q_out   (pin_sync)
   );

   // ----------------------------------------------------------------
   // write acceptance check
   // ----------------------------------------------------------------
   // a write is taken only if format and range are exact; the old
   // value survives a refused write
   always @* begin
      accept = 1'b0;
      case (cmd_code)
         `PCFGT_CMD_OPERATION:  accept = 1'b1;
         `PCFGT_CMD_ON_OFF_SRC: accept = 1'b1;
         `PCFGT_CMD_STORE_ALL:  accept = 1'b1;
         `PCFGT_CMD_VOUT_SET:
            accept = (cmd_wdata >= `PCFGT_VOUT_MIN) &&
                     (cmd_wdata <= `PCFGT_VOUT_MAX);
         `PCFGT_CMD_VOUT_MHIGH,
         `PCFGT_CMD_VOUT_MLOW:
            accept = 1'b1;
         `PCFGT_CMD_VIN_ON,
         `PCFGT_CMD_VIN_OFF:
            accept = (w_exp == `PCFGT_EXP_VIN) && w_pos &&
                     (w_mant >= `PCFGT_VIN_MIN) &&
                     (w_mant <= `PCFGT_VIN_MAX);
         `PCFGT_CMD_TON_DELAY:
            accept = (w_exp == `PCFGT_EXP_TON) && w_pos &&
                     (w_mant >= `PCFGT_TON_DELAY_MIN) &&
                     (w_mant <= `PCFGT_TON_MAX);
         `PCFGT_CMD_TON_RISE:
            accept = (w_exp == `PCFGT_EXP_TON) && w_pos &&
                     (w_mant >= `PCFGT_TON_RISE_MIN) &&
                     (w_mant <= `PCFGT_TON_MAX);
         default: accept = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // the turn-on/turn-off spacing is the host's duty and not checked
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         operation_reg            <= `PCFGT_RST_OPERATION;
         on_off_source_config_reg <= `PCFGT_RST_CFG;
         vout_set_reg             <= `PCFGT_RST_VOUT;
         vout_mhigh_reg           <= `PCFGT_RST_MHIGH;
         vout_mlow_reg            <= `PCFGT_RST_MLOW;
         vin_on_reg               <= `PCFGT_RST_VIN_ON;
         vin_off_reg              <= `PCFGT_RST_VIN_OFF;
         ton_delay_reg            <= `PCFGT_RST_TON_DELAY;
         ton_rise_reg             <= `PCFGT_RST_TON_RISE;
         cmd_ack                  <= 1'b0;
         cmd_nack                 <= 1'b0;
      end else begin
         cmd_ack  <= cmd_wr & accept;
         cmd_nack <= cmd_wr & ~accept;
         if (cmd_wr && accept) begin
            case (cmd_code)
               `PCFGT_CMD_OPERATION:
                  operation_reg <= cmd_wdata[7:0];
               `PCFGT_CMD_ON_OFF_SRC:
                  on_off_source_config_reg <=
                     (`PCFGT_RST_CFG & ~`PCFGT_CFG_WR_MASK) |
                     (cmd_wdata[7:0] & `PCFGT_CFG_WR_MASK);
               `PCFGT_CMD_VOUT_SET:   vout_set_reg   <= cmd_wdata;
               `PCFGT_CMD_VOUT_MHIGH: vout_mhigh_reg <= cmd_wdata;
               `PCFGT_CMD_VOUT_MLOW:  vout_mlow_reg  <= cmd_wdata;
               `PCFGT_CMD_VIN_ON:     vin_on_reg     <= w_mant;
               `PCFGT_CMD_VIN_OFF:    vin_off_reg    <= w_mant;
               `PCFGT_CMD_TON_DELAY:  ton_delay_reg  <= w_mant;
               `PCFGT_CMD_TON_RISE:   ton_rise_reg   <= w_mant;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // store-all snapshot to non-volatile port
   // ----------------------------------------------------------------
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         nvm_store     <= 1'b0;
         nvm_vout      <= `PCFGT_RST_VOUT;
         nvm_mhigh     <= `PCFGT_RST_MHIGH;
         nvm_mlow      <= `PCFGT_RST_MLOW;
         nvm_vin_on    <= `PCFGT_RST_VIN_ON;
         nvm_vin_off   <= `PCFGT_RST_VIN_OFF;
         nvm_ton_delay <= `PCFGT_RST_TON_DELAY;
         nvm_ton_rise  <= `PCFGT_RST_TON_RISE;
      end else begin
         nvm_store <= cmd_wr && (cmd_code == `PCFGT_CMD_STORE_ALL);
         if (cmd_wr && (cmd_code == `PCFGT_CMD_STORE_ALL)) begin
            nvm_vout      <= vout_set_reg;
            nvm_mhigh     <= vout_mhigh_reg;
            nvm_mlow      <= vout_mlow_reg;
            nvm_vin_on    <= vin_on_reg;
            nvm_vin_off   <= vin_off_reg;
            nvm_ton_delay <= ton_delay_reg;
            nvm_ton_rise  <= ton_rise_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // on/off decision and margin selection
   // ----------------------------------------------------------------
   wire       cfg_pu  = on_off_source_config_reg[`PCFGT_CFG_PU_BIT];
   wire       cfg_cmd = on_off_source_config_reg[`PCFGT_CFG_CMD_BIT];
   wire       cfg_req = on_off_source_config_reg[`PCFGT_CFG_PINREQ_BIT];
   wire       cfg_pol = on_off_source_config_reg[`PCFGT_CFG_POL_BIT];
   wire       pin_on  = pin_sync ~^ cfg_pol;
   wire       op_on   = operation_reg[`PCFGT_OP_ENABLE_BIT];
   wire [3:0] mfield  =
      operation_reg[`PCFGT_OP_MARGIN_HI:`PCFGT_OP_MARGIN_LO];
   wire       cmd_ok  = ~cfg_cmd | op_on;
   wire       pin_ok  = ~cfg_req | pin_on;
   // with power-up policy clear the module runs unconditionally
   wire       run     = ~cfg_pu | (cmd_ok & pin_ok);

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         output_enable <= 1'b0;
         margin_sel    <= 2'b00;
         vout_target   <= `PCFGT_RST_VOUT;
      end else begin
         output_enable <= run;
         if (mfield == `PCFGT_MARGIN_LOW_PAT) begin
            margin_sel  <= 2'b01;
            vout_target <= vout_mlow_reg;
         end else if (mfield == `PCFGT_MARGIN_HIGH_PAT) begin
            margin_sel  <= 2'b10;
            vout_target <= vout_mhigh_reg;
         end else begin
            margin_sel  <= 2'b00;
            vout_target <= vout_set_reg;
         end
      end
   end

   // ----------------------------------------------------------------
   // telemetry correction
   // ----------------------------------------------------------------
   // vin product kept at 27 bits so the gain never truncates early
   wire [26:0] vin_prod  = vin_adc * vin_cal_gain;
   wire [15:0] vin_scl   = {2'b00, vin_prod[26:`PCFGT_GAIN_SHIFT]};
   wire [15:0] vin_sum   = vin_scl + {{5{vin_cal_ofs[10]}}, vin_cal_ofs};
   wire [10:0] vin_final = vin_sum[15] ? 11'h000 :
                           (|vin_sum[15:10]) ? 11'h3FF : vin_sum[10:0];
   wire [15:0] vout_rd   = vout_adc + vout_cal_ofs;
   wire [10:0] iout_pos  = iout_adc[10] ? 11'h000 : iout_adc;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always @* begin
      case (cmd_code)
         `PCFGT_CMD_OPERATION:  read_next = {8'h00, operation_reg};
         `PCFGT_CMD_ON_OFF_SRC:
            read_next = {8'h00, on_off_source_config_reg};
         `PCFGT_CMD_VOUT_MODE:
            read_next = {8'h00, `PCFGT_EXP_VOUT};
         `PCFGT_CMD_VOUT_SET:   read_next = vout_set_reg;
         `PCFGT_CMD_VOUT_MHIGH: read_next = vout_mhigh_reg;
         `PCFGT_CMD_VOUT_MLOW:  read_next = vout_mlow_reg;
         `PCFGT_CMD_VIN_ON:
            read_next = {`PCFGT_EXP_VIN, vin_on_reg};
         `PCFGT_CMD_VIN_OFF:
            read_next = {`PCFGT_EXP_VIN, vin_off_reg};
         `PCFGT_CMD_TON_DELAY:
            read_next = {`PCFGT_EXP_TON, ton_delay_reg};
         `PCFGT_CMD_TON_RISE:
            read_next = {`PCFGT_EXP_TON, ton_rise_reg};
         `PCFGT_CMD_READ_VOUT:  read_next = vout_rd;
         `PCFGT_CMD_READ_VIN:
            read_next = {`PCFGT_EXP_VIN, vin_final};
         `PCFGT_CMD_READ_IOUT:
            read_next = {`PCFGT_EXP_IOUT, iout_pos};
         `PCFGT_CMD_VOUT_OFS:   read_next = vout_cal_ofs;
         `PCFGT_CMD_VIN_OFS:
            read_next = {`PCFGT_EXP_VIN, vin_cal_ofs};
         `PCFGT_CMD_VIN_GAIN:   read_next = vin_cal_gain;
         default:               read_next = 16'h0000;
      endcase
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_rdata <= 16'h0000;
      end else begin
         cmd_rdata <= read_next;
      end
   end
endmodule
`default_nettype wire

// *** pcfgt_bank_chk.sv ***
// assertion checker for the pmbus command register bank
`default_nettype none
`include "pcfgt_regs.vh"
module pcfgt_bank_chk (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        nrst,
   // command port
   input wire logic        cmd_wr,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic        cmd_ack,
   input wire logic        cmd_nack,
   // store and control
   input wire logic        nvm_store,
   input wire logic [15:0] nvm_vout,
   input wire logic [1:0]  margin_sel,
   input wire logic [10:0] vin_on_level,
   input wire logic [10:0] ton_delay_level
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_vin_bad;
      cmd_wr && cmd_code == `PCFGT_CMD_VIN_ON
         && (cmd_wdata[15:11] != `PCFGT_EXP_VIN
         || cmd_wdata[10:0] < `PCFGT_VIN_MIN
         || cmd_wdata[10:0] > `PCFGT_VIN_MAX);
   endsequence
   sequence s_op_wr;
      cmd_wr && cmd_code == `PCFGT_CMD_OPERATION;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_ONE_ANSWER: assert property (cmd_wr |=> cmd_ack != cmd_nack)
      else $error("write got no single answer");
   AST_NO_ANSWER: assert property (!cmd_wr |=> !cmd_ack
      && !cmd_nack) else $error("answer without a write");
   AST_STORE: assert property (cmd_wr
      && cmd_code == `PCFGT_CMD_STORE_ALL |=> nvm_store)
      else $error("store-all gave no store pulse");
   AST_STORE_CAUSE: assert property (nvm_store |-> $past(cmd_wr)
      && $past(cmd_code) == `PCFGT_CMD_STORE_ALL)
      else $error("store pulse without store-all");
   AST_NVM_HOLD: assert property (!nvm_store |-> $stable(nvm_vout))
      else $error("stored setpoint moved without store");
   AST_VIN_BAD: assert property (s_vin_bad |=> cmd_nack
      ##0 $stable(vin_on_level)) else $error("bad turn-on word taken");
   AST_VIN_RANGE: assert property (vin_on_level >= `PCFGT_VIN_MIN
      && vin_on_level <= `PCFGT_VIN_MAX) else $error("turn-on out of range");
   AST_TON_RANGE: assert property (ton_delay_level >= 11'h014
      && ton_delay_level <= 11'h3E8) else $error("delay out of range");
   AST_MARGIN_LO: assert property (s_op_wr ##0 cmd_wdata[5:2] == 4'h6
      |-> ##[1:2] margin_sel == 2'b01) else $error("margin low not set");
   AST_MARGIN_OFF: assert property (s_op_wr ##0 ~|cmd_wdata[5:4]
      |-> ##[1:2] margin_sel == 2'b00) else $error("margin not off");
endmodule
bind pcfgt_bank pcfgt_bank_chk i_pcfgt_bank_chk (.ref_clk, .nrst, .cmd_wr,
   .cmd_code, .cmd_wdata, .cmd_ack, .cmd_nack, .nvm_store, .nvm_vout,
   .margin_sel, .vin_on_level, .ton_delay_level);
`default_nettype wire

// *** pcfgt_host.sv ***
// host controller model driving the command port
`default_nettype none
module pcfgt_host (
   // clock
   input  wire logic        ref_clk,
   // command port
   output var  logic        cmd_wr,
   output var  logic [7:0]  cmd_code,
   output var  logic [15:0] cmd_wdata,
   input  wire logic [15:0] cmd_rdata,
   input  wire logic        cmd_ack,
   input  wire logic        cmd_nack
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_wr = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // whole word in one strobe; random idle gap mimics a slow host
   task automatic wr(input logic [7:0] c, input logic [15:0] d,
                     output logic [1:0] resp);
      repeat ($urandom_range(2, 0)) @(posedge ref_clk);
      @(posedge ref_clk);
      cmd_wr <= 1'b1;
      cmd_code <= c;
      cmd_wdata <= d;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
      resp = 2'b00;
      for (int i = 0; i < 4 && resp == 2'b00; i++) begin
         #1;
         resp = {cmd_nack, cmd_ack};
         if (resp == 2'b00) @(posedge ref_clk);
      end
   endtask
   task automatic rd(input logic [7:0] c, output logic [15:0] q);
      @(posedge ref_clk);
      cmd_code <= c;
      @(posedge ref_clk);
      #1;
      q = cmd_rdata;
   endtask
endmodule
`default_nettype wire

// *** pcfgt_regs.vh ***
// constants for the pmbus configuration and telemetry command bank
`ifndef PCFGT_REGS_VH
`define PCFGT_REGS_VH
// ----------------------------------------------------------------
// command codes (register offsets)
// ----------------------------------------------------------------
`define PCFGT_CMD_OPERATION     8'h01
`define PCFGT_CMD_ON_OFF_SRC    8'h02
`define PCFGT_CMD_STORE_ALL     8'h11
`define PCFGT_CMD_VOUT_MODE     8'h20
`define PCFGT_CMD_VOUT_SET      8'h21
`define PCFGT_CMD_VOUT_MHIGH    8'h25
`define PCFGT_CMD_VOUT_MLOW     8'h26
`define PCFGT_CMD_VIN_ON        8'h35
`define PCFGT_CMD_VIN_OFF       8'h36
`define PCFGT_CMD_TON_DELAY     8'h60
`define PCFGT_CMD_TON_RISE      8'h61
`define PCFGT_CMD_READ_VIN      8'h88
`define PCFGT_CMD_READ_VOUT     8'h8B
`define PCFGT_CMD_READ_IOUT     8'h8C
`define PCFGT_CMD_VOUT_OFS      8'hD0
`define PCFGT_CMD_VIN_OFS       8'hD1
`define PCFGT_CMD_VIN_GAIN      8'hD2
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCFGT_OP_ENABLE_BIT     7
`define PCFGT_OP_MARGIN_HI      5
`define PCFGT_OP_MARGIN_LO      2
`define PCFGT_CFG_PU_BIT        4
`define PCFGT_CFG_CMD_BIT       3
`define PCFGT_CFG_PINREQ_BIT    2
`define PCFGT_CFG_POL_BIT       1
`define PCFGT_CFG_ACT_BIT       0
`define PCFGT_CFG_WR_MASK       8'h0C
`define PCFGT_MARGIN_LOW_PAT    4'h6
`define PCFGT_MARGIN_HIGH_PAT   4'hA
// ----------------------------------------------------------------
// exponents, in the 5-bit field of the high byte; vout's is the low byte of vout mode
// ----------------------------------------------------------------
`define PCFGT_EXP_VOUT          8'h14
`define PCFGT_EXP_VIN           5'h1D
`define PCFGT_EXP_TON           5'h1F
`define PCFGT_EXP_IOUT          5'h1C
// ----------------------------------------------------------------
// permitted mantissa ranges
// ----------------------------------------------------------------
`define PCFGT_VIN_MIN           11'h100
`define PCFGT_VIN_MAX           11'h170
`define PCFGT_VIN_HYST          11'h010
`define PCFGT_TON_DELAY_MIN     11'h014
`define PCFGT_TON_RISE_MIN      11'h01E
`define PCFGT_TON_MAX           11'h3E8
`define PCFGT_VOUT_MIN          16'h819A
`define PCFGT_VOUT_MAX          16'hD333
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCFGT_RST_OPERATION     8'h80
`define PCFGT_RST_CFG           8'h1F
`define PCFGT_RST_VOUT          16'hC000
`define PCFGT_RST_MHIGH         16'hC666
`define PCFGT_RST_MLOW          16'hB99A
`define PCFGT_RST_VIN_ON        11'h120
`define PCFGT_RST_VIN_OFF       11'h110
`define PCFGT_RST_TON_DELAY     11'h014
`define PCFGT_RST_TON_RISE      11'h01E
`define PCFGT_GAIN_SHIFT        13
`endif

// *** pcfgt_sync.v ***
// two-flop synchroniser for one asynchronous level
`default_nettype none
module pcfgt_sync (
   // clock and reset
   input  wire ref_clk,
   input  wire nrst,
   // level
   input  wire d_in,
   output reg  q_out
);
   reg meta_reg;

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= 1'b0;
         q_out    <= 1'b0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// *** tb_pcfgt_bank.sv ***
// self-checking bench for the pmbus command register bank
`default_nettype none
module tb_pcfgt_bank;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, nrst, cmd_wr, cmd_ack, cmd_nack, onoff_pin;
   logic        nvm_store, output_enable;
   logic [1:0]  margin_sel, resp;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, vout_adc, vout_cal_ofs, vin_cal_gain;
   logic [15:0] nvm_vout, nvm_mhigh, nvm_mlow, vout_target, q;
   logic [10:0] vin_adc, iout_adc, vin_cal_ofs, nvm_vin_on, nvm_vin_off;
   logic [10:0] nvm_ton_delay, nvm_ton_rise, vin_on_level, vin_off_level;
   logic [10:0] ton_delay_level, ton_rise_level;
   int          fails, tests_run, v, r, mdl[256];
   logic [7:0]  rc[9] = '{8'h02, 8'h20, 8'h21, 8'h25, 8'h26, 8'h35, 8'h36,
                          8'h60, 8'h61};
   logic [15:0] rv[9] = '{16'h001F, 16'h0014, 16'hC000, 16'hC666, 16'hB99A,
                          16'hE920, 16'hE910, 16'hF814, 16'hF81E};
   // host keeps turn-on at least 2 V above turn-off at every step
   logic [23:0] wt[18] = '{24'h36E900, 24'h36E8FF, 24'h35E970, 24'h35E971,
      24'h35F120, 24'h60F814, 24'h60F813, 24'h60FBE8, 24'h60FBE9, 24'h61F81D,
      24'h61F81E, 24'h21819A, 24'h218199, 24'h21D333, 24'h21D334, 24'h55C000,
      24'h25D000, 24'h269000};
   logic [7:0]  mo[4] = '{8'h98, 8'hA8, 8'h84, 8'h80};
   logic [7:0]  cf[4] = '{8'h1F, 8'h17, 8'h1B, 8'h00};
   pcfgt_bank i_pcfgt_bank (.ref_clk, .nrst, .cmd_wr, .cmd_code, .cmd_wdata,
      .cmd_rdata, .cmd_ack, .cmd_nack, .onoff_pin, .vout_adc, .vin_adc,
      .iout_adc, .vout_cal_ofs, .vin_cal_ofs, .vin_cal_gain, .nvm_store,
      .nvm_vout, .nvm_mhigh, .nvm_mlow, .nvm_vin_on, .nvm_vin_off,
      .nvm_ton_delay, .nvm_ton_rise, .output_enable, .margin_sel,
      .vout_target, .vin_on_level, .vin_off_level, .ton_delay_level,
      .ton_rise_level);
   pcfgt_host i_pcfgt_host (.ref_clk, .cmd_wr, .cmd_code, .cmd_wdata,
      .cmd_rdata, .cmd_ack, .cmd_nack);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // reference model
   // ----------------------------------------------------------------
   function automatic bit acc(logic [7:0] c, logic [15:0] d);
      logic [10:0] m;
      m = d[10:0];
      case (c)
         8'h35, 8'h36: return d[15:11] == 5'h1D && m >= 11'h100
                              && m <= 11'h170;
         8'h60: return d[15:11] == 5'h1F && m >= 11'h014 && m <= 11'h3E8;
         8'h61: return d[15:11] == 5'h1F && m >= 11'h01E && m <= 11'h3E8;
         8'h21: return d >= 16'h819A && d <= 16'hD333;
         8'h01, 8'h02, 8'h25, 8'h26: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   // write, compare the answer, read back and compare the levels
   task automatic wrc(input logic [7:0] c, input logic [15:0] d);
      bit a;
      a = acc(c, d);
      i_pcfgt_host.wr(c, d, resp);
      if (resp == 2'b00) begin
         fails++;
         give_verdict();
      end
      chk(16'(resp), a ? 16'h0001 : 16'h0002);
      // only the command and pin-required config bits take a write
      if (a) mdl[c] = c == 8'h02 ? 16'h0013 | d & 16'h000C : d;
      i_pcfgt_host.rd(c, q);
      chk(q, 16'(mdl[c]));
      chk(16'(vin_on_level), 16'(mdl[8'h35][10:0]));
      chk(16'(vin_off_level), 16'(mdl[8'h36][10:0]));
      chk(16'(ton_delay_level), 16'(mdl[8'h60][10:0]));
      chk(16'(ton_rise_level), 16'(mdl[8'h61][10:0]));
   endtask
   initial begin
      {nrst, onoff_pin, vout_adc, vout_cal_ofs, vin_cal_gain} = 50'h1;
      {vin_adc, iout_adc, vin_cal_ofs} = 33'h0;
      fails = 0;
      tests_run = 0;
      v = $urandom(32'h61C046C7);
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      mdl[8'h01] = 16'h0080;
      foreach (rc[i]) begin
         mdl[rc[i]] = rv[i];
         i_pcfgt_host.rd(rc[i], q);
         chk(q, rv[i]);
      end
      foreach (wt[i]) wrc(wt[i][23:16], wt[i][15:0]);
      repeat (24) begin
         v = $urandom_range(2, 0);
         wrc(v == 0 ? 8'h60 : v == 1 ? 8'h61 : 8'h21, v == 2 ? 16'($urandom)
             : {5'h1F, 11'($urandom_range(1100, 0))});
      end
      repeat (12) begin
         @(posedge ref_clk);
         vout_adc <= 16'($urandom);
         vout_cal_ofs <= 16'($urandom_range(400, 0) - 200);
         vin_adc <= 11'($urandom_range(1023, 0));
         vin_cal_gain <= 16'($urandom_range(12000, 4000));
         vin_cal_ofs <= 11'($urandom_range(60, 0) - 30);
         iout_adc <= 11'($urandom_range(1100, 0) - 100);
         i_pcfgt_host.rd(8'h8B, q);
         chk(q, vout_adc + vout_cal_ofs);
         r = (int'(vin_adc) * int'(vin_cal_gain) >> 13)
             + int'($signed(vin_cal_ofs));
         r = r < 0 ? 0 : r > 1023 ? 1023 : r;
         i_pcfgt_host.rd(8'h88, q);
         chk(q, {5'h1D, 11'(r)});
         r = $signed(iout_adc) < 0 ? 0 : int'(iout_adc);
         i_pcfgt_host.rd(8'h8C, q);
         chk(q, {5'h1C, 11'(r)});
         i_pcfgt_host.rd(8'hD0, q);
         chk(q, vout_cal_ofs);
         i_pcfgt_host.rd(8'hD1, q);
         chk(q, {5'h1D, vin_cal_ofs});
         i_pcfgt_host.rd(8'hD2, q);
         chk(q, vin_cal_gain);
      end
      foreach (mo[i]) begin
         wrc(8'h01, {8'h00, mo[i]});
         v = mo[i][5:4] == 2'b01 ? 8'h26
             : mo[i][5:4] == 2'b10 ? 8'h25 : 8'h21;
         chk(16'(margin_sel), 16'(mo[i][5:4]));
         chk(vout_target, 16'(mdl[v]));
      end
      chk(nvm_vout, 16'hC000);
      i_pcfgt_host.wr(8'h11, 16'h0000, resp);
      chk(16'(resp), 16'h0001);
      chk(16'(nvm_store), 16'h0001);
      chk(nvm_vout, 16'(mdl[8'h21]));
      chk(nvm_mhigh, 16'(mdl[8'h25]));
      chk(nvm_mlow, 16'(mdl[8'h26]));
      chk({nvm_vin_on, 5'h0}, 16'(mdl[8'h35] << 5));
      chk({nvm_vin_off, 5'h0}, 16'(mdl[8'h36] << 5));
      chk({nvm_ton_delay, 5'h0}, 16'(mdl[8'h60] << 5));
      chk({nvm_ton_rise, 5'h0}, 16'(mdl[8'h61] << 5));
      foreach (cf[i]) for (int e = 0; e < 4; e++) begin
         wrc(8'h02, {8'h00, cf[i]});
         wrc(8'h01, {8'h00, e[1], 7'h00});
         @(posedge ref_clk);
         onoff_pin <= e[0];
         repeat (5) @(posedge ref_clk);
         #1;
         v = (cf[i][3] ? e[1] : 1) && (cf[i][2] ? e[0] : 1);
         chk(16'(output_enable), 16'(v));
      end
      // reset again mid-run: every setting falls back to its default
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      foreach (rc[i]) begin
         i_pcfgt_host.rd(rc[i], q);
         chk(q, rv[i]);
      end
      chk(16'(margin_sel), 16'h0000);
      chk(16'({nvm_store, cmd_ack, cmd_nack}), 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
